// ==== irx_defines.svh ====
`ifndef IRX_DEFINES_SVH
`define IRX_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IRX_OFS_CTRL 8'h00
`define IRX_OFS_OWN 8'h04
`define IRX_OFS_TX 8'h08
`define IRX_OFS_RX 8'h0c
`define IRX_OFS_FLAGS 8'h10
`define IRX_OFS_MASK 8'h14

// ----------------------------------------
// field widths and positions
// ----------------------------------------
`define IRX_CTRL_W 4
`define IRX_FLAGS_W 7
`define IRX_EVENT_W 6
`define IRX_OWN_W 7
`define IRX_BYTE_W 8
`define IRX_DIR_POS 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define IRX_CTRL_RST 4'h0
`define IRX_FLAGS_RST 7'h00
`define IRX_MASK_RST 7'h00
`define IRX_OWN_RST 7'h00
`define IRX_BYTE_RST 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define IRX_CLK_PERIOD_NS 10
`define IRX_SCL_PERIOD_NS 10000
`define IRX_QUARTER_CYCLES (`IRX_SCL_PERIOD_NS / (4 * `IRX_CLK_PERIOD_NS))
`define IRX_LAST_BIT 4'h8

`endif

// ==== irx_pkg.sv ====
`default_nettype none

package irx_pkg;

  // ----------------------------------------
  // register layouts
  // ----------------------------------------
  typedef struct packed {
    logic slave_en;
    logic send_not_ack_bit;
    logic issue_stop_bit;
    logic issue_start_bit;
  } irx_ctrl_type;

  typedef struct packed {
    logic slave_direction_bit;
    logic byte_done_flag;
    logic stop_seen_flag;
    logic start_seen_flag;
    logic not_ack_received_flag;
    logic rx_buffer_full_flag;
    logic tx_buffer_empty_flag;
  } irx_flags_type;

  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    irx_m_idle = 3'h0,
    irx_m_start = 3'h1,
    irx_m_hold = 3'h3,
    irx_m_bit = 3'h2,
    irx_m_stop = 3'h6
  } irx_mstate_type;

  typedef enum logic [1:0] {
    irx_s_idle = 2'h0,
    irx_s_recv = 2'h1,
    irx_s_ack = 2'h3,
    irx_s_skip = 2'h2
  } irx_sstate_type;

endpackage

`default_nettype wire

// ==== irx_pin_sync.sv ====
`default_nettype none

module irx_pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;
  logic [WIDTH-1:0] next_out;

  // a change counts only once stages two and three agree
  always_comb begin
    next_out = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (ff2[i] == ff3[i]) begin
        next_out[i] = ff3[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      ff1 <= async_in;
      ff2 <= ff1;
      ff3 <= ff2;
      sync_out <= next_out;
    end
  end

endmodule // irx_pin_sync

`default_nettype wire

// ==== irx_i2c_receive.sv ====
// Implementation choices: the register addresses and register access over APB.

`include "irx_defines.svh"

`default_nettype none

module irx_i2c_receive #(
  parameter int QUARTER = `IRX_QUARTER_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // interrupt
  output logic irq
);

  import irx_pkg::*;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [1:0] pin_s;
  logic scl_s;
  logic sda_s;

  irx_pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `IRX_OFS_CTRL) || (a == `IRX_OFS_OWN) || (a == `IRX_OFS_TX) ||
             (a == `IRX_OFS_RX) || (a == `IRX_OFS_FLAGS) || (a == `IRX_OFS_MASK);
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  irx_ctrl_type ctrl, next_ctrl;
  irx_flags_type flags, next_flags;
  irx_flags_type mask, next_mask;
  logic [6:0] own_addr, next_own_addr;
  logic [7:0] tx_byte, next_tx_byte;
  logic tx_pending, next_tx_pending;
  logic [7:0] rx_byte, next_rx_byte;
  logic [31:0] next_prdata;

  // ----------------------------------------
  // master engine
  // ----------------------------------------
  irx_mstate_type m_state, next_m_state;
  irx_sstate_type s_state, next_s_state;
  logic [1:0] m_phase, next_m_phase;
  logic [15:0] m_qcnt, next_m_qcnt;
  logic [3:0] m_bcnt, next_m_bcnt;
  logic [7:0] m_shift, next_m_shift;
  logic m_addr, next_m_addr;
  logic m_dir, next_m_dir;
  logic m_read, next_m_read;
  logic m_done, next_m_done;
  logic m_tick;
  logic m_scl_oe, m_sda_oe;
  logic m_ev_start, m_ev_rx, m_ev_nack, m_ev_stop, m_take_tx;
  logic m_clr_start, m_clr_stop, m_clr_nack;

  always_comb begin
    next_m_state = m_state;
    next_m_phase = m_phase;
    next_m_bcnt = m_bcnt;
    next_m_shift = m_shift;
    next_m_addr = m_addr;
    next_m_dir = m_dir;
    next_m_read = m_read;
    next_m_done = m_done;
    {m_ev_start, m_ev_rx, m_ev_nack, m_ev_stop, m_take_tx} = 5'h00;
    {m_clr_start, m_clr_stop, m_clr_nack} = 3'h0;
    m_scl_oe = 1'b0;
    m_sda_oe = 1'b0;
    m_tick = (m_qcnt == 16'(QUARTER - 1));
    // the quarter timer only runs while the master owns the bus and moves
    if (m_state == irx_m_idle || m_state == irx_m_hold || m_tick) begin
      next_m_qcnt = 16'h0000;
    end else begin
      next_m_qcnt = m_qcnt + 16'h0001;
    end
    case (m_state)
      irx_m_idle: begin
        // no arbitration: only start on a quiet bus with the slave side idle
        if (ctrl.issue_start_bit && scl_s && sda_s && s_state == irx_s_idle) begin
          next_m_state = irx_m_start;
          next_m_phase = 2'h0;
          next_m_read = 1'b0;
          next_m_done = 1'b0;
          m_clr_start = 1'b1;
        end
      end
      irx_m_start: begin
        m_sda_oe = (m_phase != 2'h0);
        m_scl_oe = (m_phase == 2'h2);
        if (m_tick) begin
          if (m_phase == 2'h2) begin
            m_ev_start = 1'b1;
            next_m_state = irx_m_hold;
            next_m_phase = 2'h0;
          end else begin
            next_m_phase = m_phase + 2'h1;
          end
        end
      end
      irx_m_hold: begin
        m_scl_oe = 1'b1;
        if (ctrl.issue_stop_bit) begin
          next_m_state = irx_m_stop;
          next_m_phase = 2'h0;
          m_clr_stop = 1'b1;
        end else if (tx_pending && !m_read && !m_done) begin
          m_take_tx = 1'b1;
          next_m_shift = tx_byte;
          next_m_dir = tx_byte[`IRX_DIR_POS];
          next_m_addr = 1'b1;
          next_m_bcnt = 4'h0;
          next_m_phase = 2'h0;
          next_m_state = irx_m_bit;
        end else if (m_read && !m_done) begin
          next_m_addr = 1'b0;
          next_m_bcnt = 4'h0;
          next_m_phase = 2'h0;
          next_m_state = irx_m_bit;
        end
      end
      irx_m_bit: begin
        m_scl_oe = ~m_phase[1];
        if (m_bcnt == `IRX_LAST_BIT) begin
          m_sda_oe = !m_addr && !ctrl.send_not_ack_bit;
        end else begin
          m_sda_oe = m_addr && !m_shift[7];
        end
        if (m_tick) begin
          next_m_phase = m_phase + 2'h1;
          if (m_phase == 2'h2 && !m_addr && m_bcnt != `IRX_LAST_BIT) begin
            next_m_shift = {m_shift[6:0], sda_s};
          end
          if (m_phase == 2'h3) begin
            if (m_bcnt != `IRX_LAST_BIT) begin
              next_m_bcnt = m_bcnt + 4'h1;
              if (m_addr) begin
                next_m_shift = {m_shift[6:0], 1'b0};
              end
            end else begin
              next_m_state = irx_m_hold;
              if (m_addr) begin
                if (sda_s) begin
                  m_ev_nack = 1'b1;
                  next_m_done = 1'b1;
                end else begin
                  // write direction is not this block's job: park until stop
                  next_m_read = m_dir;
                  next_m_done = ~m_dir;
                end
              end else begin
                m_ev_rx = 1'b1;
                if (ctrl.send_not_ack_bit) begin
                  m_clr_nack = 1'b1;
                  next_m_done = 1'b1;
                end
              end
            end
          end
        end
      end
      irx_m_stop: begin
        m_scl_oe = (m_phase == 2'h0);
        m_sda_oe = (m_phase != 2'h2);
        if (m_tick) begin
          if (m_phase == 2'h2) begin
            m_ev_stop = 1'b1;
            next_m_state = irx_m_idle;
            next_m_phase = 2'h0;
          end else begin
            next_m_phase = m_phase + 2'h1;
          end
        end
      end
      default: begin
        next_m_state = irx_m_idle;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      m_state <= irx_m_idle;
      m_phase <= 2'h0;
      m_qcnt <= 16'h0000;
      m_bcnt <= 4'h0;
      m_shift <= `IRX_BYTE_RST;
      m_addr <= 1'b0;
      m_dir <= 1'b0;
      m_read <= 1'b0;
      m_done <= 1'b0;
    end else begin
      m_state <= next_m_state;
      m_phase <= next_m_phase;
      m_qcnt <= next_m_qcnt;
      m_bcnt <= next_m_bcnt;
      m_shift <= next_m_shift;
      m_addr <= next_m_addr;
      m_dir <= next_m_dir;
      m_read <= next_m_read;
      m_done <= next_m_done;
    end
  end

  // ----------------------------------------
  // slave engine
  // ----------------------------------------
  logic [3:0] s_bcnt, next_s_bcnt;
  logic [7:0] s_shift, next_s_shift;
  logic s_addr, next_s_addr;
  logic s_dir, next_s_dir;
  logic scl_q, sda_q;
  logic s_rise, s_fall, s_start, s_stop;
  logic s_ev_start, s_ev_rx, s_ev_stop, s_clr_nack;

  always_comb begin
    next_s_state = s_state;
    next_s_bcnt = s_bcnt;
    next_s_shift = s_shift;
    next_s_addr = s_addr;
    next_s_dir = s_dir;
    {s_ev_start, s_ev_rx, s_ev_stop, s_clr_nack} = 4'h0;
    s_rise = scl_s && !scl_q;
    s_fall = !scl_s && scl_q;
    s_start = scl_s && scl_q && sda_q && !sda_s;
    s_stop = scl_s && scl_q && !sda_q && sda_s;
    if (!ctrl.slave_en || m_state != irx_m_idle) begin
      next_s_state = irx_s_idle;
    end else if (s_start) begin
      // a repeated start re-reads the address and may flip direction
      next_s_state = irx_s_recv;
      next_s_bcnt = 4'h0;
      next_s_addr = 1'b1;
    end else if (s_stop) begin
      s_ev_stop = (s_state != irx_s_idle);
      next_s_state = irx_s_idle;
    end else begin
      case (s_state)
        irx_s_idle: begin
          next_s_bcnt = 4'h0;
        end
        irx_s_recv: begin
          if (s_rise && s_bcnt != `IRX_LAST_BIT) begin
            next_s_shift = {s_shift[6:0], sda_s};
            next_s_bcnt = s_bcnt + 4'h1;
          end
          if (s_fall && s_bcnt == `IRX_LAST_BIT) begin
            if (s_addr) begin
              if (s_shift[7:1] == own_addr) begin
                s_ev_start = 1'b1;
                next_s_dir = s_shift[`IRX_DIR_POS];
                next_s_addr = 1'b0;
                next_s_state = irx_s_ack;
              end else begin
                next_s_state = irx_s_skip;
              end
            end else begin
              s_ev_rx = 1'b1;
              if (ctrl.send_not_ack_bit) begin
                s_clr_nack = 1'b1;
                next_s_state = irx_s_skip;
              end else begin
                next_s_state = irx_s_ack;
              end
            end
          end
        end
        irx_s_ack: begin
          if (s_fall) begin
            // slave transmit is handled elsewhere: step aside after the ack
            next_s_state = s_dir ? irx_s_skip : irx_s_recv;
            next_s_bcnt = 4'h0;
          end
        end
        irx_s_skip: begin
          next_s_bcnt = 4'h0;
        end
        default: begin
          next_s_state = irx_s_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_state <= irx_s_idle;
      s_bcnt <= 4'h0;
      s_shift <= `IRX_BYTE_RST;
      s_addr <= 1'b0;
      s_dir <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      s_state <= next_s_state;
      s_bcnt <= next_s_bcnt;
      s_shift <= next_s_shift;
      s_addr <= next_s_addr;
      s_dir <= next_s_dir;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ----------------------------------------
  // registers and apb
  // ----------------------------------------
  logic wr_en, rd_setup;
  logic [`IRX_EVENT_W-1:0] ev_set;

  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    next_ctrl = ctrl;
    next_mask = mask;
    next_own_addr = own_addr;
    next_tx_byte = tx_byte;
    next_tx_pending = tx_pending && !m_take_tx;
    next_rx_byte = rx_byte;
    next_prdata = prdata;
    // hardware clears the one-shot commands once acted upon
    if (m_clr_start) next_ctrl.issue_start_bit = 1'b0;
    if (m_clr_stop) next_ctrl.issue_stop_bit = 1'b0;
    if (m_clr_nack || s_clr_nack) next_ctrl.send_not_ack_bit = 1'b0;
    if (m_ev_rx) next_rx_byte = m_shift;
    if (s_ev_rx) next_rx_byte = s_shift;
    ev_set = {s_ev_rx, m_ev_stop || s_ev_stop, m_ev_start || s_ev_start,
              m_ev_nack, m_ev_rx || s_ev_rx, m_ev_start || m_take_tx};
    next_flags = flags;
    if (wr_en && paddr == `IRX_OFS_FLAGS) begin
      next_flags = irx_flags_type'(flags & ~pwdata[`IRX_FLAGS_W-1:0]);
    end
    // a set in the same cycle as its clear wins
    next_flags = irx_flags_type'(next_flags | {1'b0, ev_set});
    next_flags.slave_direction_bit = s_dir;
    if (wr_en) begin
      case (paddr)
        `IRX_OFS_CTRL: next_ctrl = irx_ctrl_type'(pwdata[`IRX_CTRL_W-1:0]);
        `IRX_OFS_OWN: next_own_addr = pwdata[`IRX_OWN_W-1:0];
        `IRX_OFS_TX: begin
          next_tx_byte = pwdata[`IRX_BYTE_W-1:0];
          next_tx_pending = 1'b1;
        end
        `IRX_OFS_MASK: next_mask = irx_flags_type'(pwdata[`IRX_FLAGS_W-1:0]);
        default: next_tx_pending = next_tx_pending;
      endcase
    end
    if (rd_setup) begin
      case (paddr)
        `IRX_OFS_CTRL: next_prdata = {28'h0000000, ctrl};
        `IRX_OFS_OWN: next_prdata = {25'h0000000, own_addr};
        `IRX_OFS_TX: next_prdata = {24'h000000, tx_byte};
        `IRX_OFS_RX: next_prdata = {24'h000000, rx_byte};
        `IRX_OFS_FLAGS: next_prdata = {25'h0000000, flags};
        `IRX_OFS_MASK: next_prdata = {25'h0000000, mask};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= `IRX_CTRL_RST;
      flags <= `IRX_FLAGS_RST;
      mask <= `IRX_MASK_RST;
      own_addr <= `IRX_OWN_RST;
      tx_byte <= `IRX_BYTE_RST;
      tx_pending <= 1'b0;
      rx_byte <= `IRX_BYTE_RST;
      prdata <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
      flags <= next_flags;
      mask <= next_mask;
      own_addr <= next_own_addr;
      tx_byte <= next_tx_byte;
      tx_pending <= next_tx_pending;
      rx_byte <= next_rx_byte;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = m_scl_oe;
  assign sda_oe = m_sda_oe || (s_state == irx_s_ack);
  // direction is status, not an event, so it never raises the line
  assign irq = |(flags[`IRX_EVENT_W-1:0] & mask[`IRX_EVENT_W-1:0]);

endmodule // irx_i2c_receive

`default_nettype wire

// ==== irx_checker.sv ====
`include "irx_defines.svh"
`default_nettype none

module irx_checker #(
  parameter int QUARTER = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // two-wire bus and interrupt
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 8 * QUARTER;
  logic acc;
  logic mapped;
  logic [5:0] mask_sh;
  logic [5:0] next_mask_sh;
  assign acc = psel && penable;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `IRX_OFS_MASK;
  // shadow of the mask, so a flag read can be tied to irq
  always_comb begin
    next_mask_sh = mask_sh;
    if (acc && pwrite && paddr == `IRX_OFS_MASK) next_mask_sh = pwdata[5:0];
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mask_sh <= 6'h00;
    else mask_sh <= next_mask_sh;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_unmapped; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; acc && mapped |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_quiet; $fell(rst) |-> !scl_oe && !sda_oe && !irq ##1 !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
  property p_drain; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("bus driven high");
  property p_irq_flag;
    acc && !pwrite && paddr == `IRX_OFS_FLAGS && (prdata[5:0] & mask_sh) != 6'h00 |-> irq;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("enabled flag without irq");
  property p_irq_off; acc && pwrite && paddr == `IRX_OFS_MASK && pwdata[5:0] == 6'h00 |=> !irq [*2]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
  property p_start;
    acc && pwrite && paddr == `IRX_OFS_CTRL && pwdata[0] && !pwdata[3] && scl_in && sda_in
      && !scl_oe && !sda_oe |-> ##[1:LIM] (sda_oe && !scl_oe) ##[1:LIM] (sda_oe && scl_oe);
  endproperty
  a_start: assert property (p_start) else $error("no start after request");
  property p_stop; $fell(sda_oe) && !scl_oe && scl_in |-> !scl_oe [*8]; endproperty
  a_stop: assert property (p_stop) else $error("clock pulled after stop");
endmodule // irx_checker

`default_nettype wire

// ==== irx_partner.sv ====
`default_nettype none

module irx_partner #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // pulls, high pulls the line low
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;
  logic [7:0] data [2];
  logic acked;
  int nbytes;
  // ----------------------------------------
  // remote slave answering reads to ADDR
  // ----------------------------------------
  initial begin
    data[0] = 8'ha5;
    data[1] = 8'h3c;
    scl_low = 1'b0;
    sda_low = 1'b0;
    nbytes = 0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      repeat (8) begin
        @(posedge scl);
        rx = {rx[6:0], sda};
      end
      @(negedge scl);
      if (rx == {ADDR, 1'b1}) begin
        sda_low = 1'b1;
        nbytes = 0;
        do begin
          @(negedge scl);
          for (int k = 7; k >= 0; k--) begin
            sda_low = !data[nbytes[0]][k];
            @(negedge scl);
          end
          sda_low = 1'b0;
          nbytes++;
          @(posedge scl);
          acked = !sda;
        end while (acked);
      end
    end
  end
  // ----------------------------------------
  // remote master, 160 ns bit period
  // ----------------------------------------
  task automatic m_start();
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl_low = 1'b1;
    #40;
  endtask
  task automatic m_byte(input logic [7:0] b, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      sda_low = !b[k];
      #40 scl_low = 1'b0;
      #80 scl_low = 1'b1;
      #40;
    end
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #40 ack = !sda;
    #40 scl_low = 1'b1;
    #40;
  endtask
  task automatic m_stop();
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b0;
    #80;
  endtask
endmodule // irx_partner

`default_nettype wire

// ==== irx_i2c_receive_tb_top.sv ====
`include "irx_defines.svh"
`default_nettype none

module irx_i2c_receive_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
  localparam logic [6:0] PEER = 7'h2a;
  localparam logic [6:0] SELF = 7'h35;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, p_scl, p_sda, slverr, ack;
  wire logic scl_bus;
  wire logic sda_bus;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  // pull-ups win unless somebody pulls low
  assign scl_bus = !(scl_oe || p_scl);
  assign sda_bus = !(sda_oe || p_sda);
  irx_i2c_receive #(.QUARTER(3)) uut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in(scl_bus), .scl_out, .scl_oe,
    .sda_in(sda_bus), .sda_out, .sda_oe, .irq);
  irx_partner #(.ADDR(PEER)) partner (.scl(scl_bus), .sda(sda_bus), .scl_low(p_scl),
    .sda_low(p_sda));
  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  // polls are bounded; the caller's compare catches a flag that never came
  task automatic wait_flag(input int b);
    for (int i = 0; i < 300; i++) begin
      rd(`IRX_OFS_FLAGS);
      if (q[b] === 1'b1) break;
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(`IRX_OFS_FLAGS);
    `CHK(q, 32'h0)
    rd(8'h40);
    `CHK({slverr, q}, 33'h100000000)
    // ----------------------------------------
    // master reads two bytes, refuses the last
    // ----------------------------------------
    wr(`IRX_OFS_CTRL, 32'h1);
    wait_flag(3);
    `CHK(q[3:0], 4'h9)
    wr(`IRX_OFS_FLAGS, 32'h9);
    wr(`IRX_OFS_TX, {24'h0, PEER, 1'b1});
    wait_flag(1);
    `CHK(irq, 1'b0)
    wr(`IRX_OFS_MASK, 32'h2);
    `CHK(irq, 1'b1)
    wr(`IRX_OFS_CTRL, 32'h4);
    rd(`IRX_OFS_RX);
    `CHK(q, 32'ha5)
    wr(`IRX_OFS_FLAGS, 32'h2);
    `CHK(irq, 1'b0)
    wait_flag(1);
    rd(`IRX_OFS_RX);
    `CHK(q, 32'h3c)
    wr(`IRX_OFS_MASK, 32'h0);
    `CHK(irq, 1'b0)
    wr(`IRX_OFS_CTRL, 32'h2);
    wait_flag(4);
    `CHK(q[4], 1'b1)
    wr(`IRX_OFS_FLAGS, 32'h7f);
    rd(`IRX_OFS_FLAGS);
    `CHK(q[5:0], 6'h0)
    `CHK(partner.nbytes, 2)
    // ----------------------------------------
    // single byte read, refused up front
    // ----------------------------------------
    wr(`IRX_OFS_CTRL, 32'h5);
    wait_flag(3);
    wr(`IRX_OFS_FLAGS, 32'h9);
    wr(`IRX_OFS_TX, {24'h0, PEER, 1'b1});
    wait_flag(1);
    rd(`IRX_OFS_RX);
    `CHK(q, 32'ha5)
    `CHK(partner.nbytes, 1)
    wr(`IRX_OFS_CTRL, 32'h2);
    wait_flag(4);
    wr(`IRX_OFS_FLAGS, 32'h7f);
    // ----------------------------------------
    // address refused, then stop
    // ----------------------------------------
    wr(`IRX_OFS_CTRL, 32'h1);
    wait_flag(3);
    wr(`IRX_OFS_FLAGS, 32'h9);
    wr(`IRX_OFS_TX, {24'h0, 7'h11, 1'b1});
    wait_flag(2);
    `CHK(q[2:1], 2'b10)
    wr(`IRX_OFS_FLAGS, 32'h4);
    wr(`IRX_OFS_CTRL, 32'h2);
    wait_flag(4);
    `CHK(q[4], 1'b1)
    wr(`IRX_OFS_FLAGS, 32'h7f);
    // ----------------------------------------
    // slave receives, refuses last, repeated start
    // ----------------------------------------
    wr(`IRX_OFS_OWN, {25'h0, SELF});
    wr(`IRX_OFS_CTRL, 32'h8);
    partner.m_start();
    partner.m_byte({SELF, 1'b0}, ack);
    rd(`IRX_OFS_FLAGS);
    `CHK({ack, q[6], q[3]}, 3'b101)
    wr(`IRX_OFS_FLAGS, 32'h8);
    partner.m_byte(8'h96, ack);
    rd(`IRX_OFS_FLAGS);
    `CHK({ack, q[5:1]}, 6'b110001)
    rd(`IRX_OFS_RX);
    `CHK(q, 32'h96)
    wr(`IRX_OFS_FLAGS, 32'h22);
    wr(`IRX_OFS_CTRL, 32'hc);
    partner.m_byte(8'h5b, ack);
    rd(`IRX_OFS_RX);
    `CHK({ack, q[7:0]}, 9'h05b)
    partner.m_start();
    partner.m_byte({SELF, 1'b1}, ack);
    rd(`IRX_OFS_FLAGS);
    `CHK({q[6], q[3]}, 2'b11)
    wr(`IRX_OFS_FLAGS, 32'h7f);
    partner.m_stop();
    rd(`IRX_OFS_FLAGS);
    `CHK(q[4], 1'b1)
    wr(`IRX_OFS_FLAGS, 32'h10);
    final_report();
  end
endmodule // irx_i2c_receive_tb_top

bind irx_i2c_receive irx_checker #(.QUARTER(QUARTER)) chk (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_out, .scl_oe, .sda_in,
  .sda_out, .sda_oe, .irq);

`default_nettype wire
